// file: verilog/rxcks_pkg.sv
package rxcks_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] RXCKS_OFF_SLOT = 8'h84;
  localparam logic [7:0] RXCKS_OFF_CHK = 8'h88;
  localparam logic [7:0] RXCKS_OFF_STAT = 8'h80;
  localparam logic [7:0] RXCKS_OFF_IEN = 8'h90;
  localparam logic [7:0] RXCKS_OFF_ICLR = 8'h94;

  // Field positions in the clock-check register.
  localparam int RXCKS_CNT_LSB = 24;
  localparam int RXCKS_MAX_LSB = 16;
  localparam int RXCKS_MIN_LSB = 8;
  localparam int RXCKS_DIV_LSB = 0;

  // Bit position of the clock fail flag in status, enable and clear.
  localparam int RXCKS_FAIL_BIT = 2;

  // Slot counter width and its highest legal value.
  localparam int RXCKS_SLOT_W = 10;
  localparam logic [9:0] RXCKS_SLOT_MAX = 10'h17F;

  // Index of the last observed clock edge in a measurement window (32 edges).
  localparam logic [4:0] RXCKS_WIN_LAST = 5'h1F;

  // Largest legal divider code; higher codes are reserved.
  localparam logic [3:0] RXCKS_DIV_MAX = 4'h8;

  // Reset values.
  localparam logic [7:0] RXCKS_BYTE_RST = 8'h00;
  localparam logic [3:0] RXCKS_DIV_RST = 4'h0;

  // Software-programmed clock-check settings.
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
    logic [3:0] div;
  } rxcks_cfg_t;

  // Result of one completed measurement window.
  typedef struct packed {
    logic done;
    logic [7:0] count;
  } rxcks_meas_t;

endpackage

// file: verilog/rxcks_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser followed by a rising-edge detector on the safe flop.
module rxcks_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise
);

  logic meta_ff; // First stage, read only by the second stage.
  logic sync_ff; // Second stage, safe to use.
  logic last_ff; // Previous safe value for edge detection.

  // The chain shifts the pin in on every clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // A rise is a one-cycle pulse.
  assign rise = sync_ff & ~last_ff;

endmodule

// file: verilog/rxcks_meter.sv
`timescale 1ns/10ps
// Counts prescaled system clocks across 32 observed clock edges.
module rxcks_meter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hf_rise,
  input wire logic [3:0] div,
  output rxcks_pkg::rxcks_meas_t meas
);

  logic [7:0] pre_ff; // Prescaler counter.
  logic [4:0] edge_ff; // Observed edges counted in this window.
  logic [7:0] cnt_ff; // Prescaled ticks in this window.
  logic done_ff; // One-cycle pulse at window end.
  logic [7:0] res_ff; // Count of the window just closed.
  logic tick; // Prescaled clock tick.
  logic [7:0] pre_mask; // Terminal value of the prescaler.
  logic [7:0] nxt_cnt; // Count including this cycle's tick.

  // The mask is 2^div - 1, so a tick comes every 2^div clocks.
  always_comb begin
    pre_mask = 8'hFF >> (4'h8 - div);
    if (div > rxcks_pkg::RXCKS_DIV_MAX) begin
      pre_mask = 8'hFF; // Reserved codes behave as the largest divide.
    end
    tick = ((pre_ff & pre_mask) == pre_mask);
    nxt_cnt = cnt_ff + {7'h00, tick};
  end

  // Prescaler runs freely on the system clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= rxcks_pkg::RXCKS_BYTE_RST;
    end else begin
      pre_ff <= pre_ff + 8'h01;
    end
  end

  // Window edge counter and tick accumulator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_ff <= 5'h00;
      cnt_ff <= rxcks_pkg::RXCKS_BYTE_RST;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (hf_rise && edge_ff == rxcks_pkg::RXCKS_WIN_LAST) begin
        edge_ff <= 5'h00;
        cnt_ff <= rxcks_pkg::RXCKS_BYTE_RST;
        done_ff <= 1'b1;
      end else begin
        if (hf_rise) begin
          edge_ff <= edge_ff + 5'h01;
        end
        if (tick && cnt_ff != 8'hFF) begin
          cnt_ff <= nxt_cnt; // Saturates rather than wrapping.
        end
      end
    end
  end

  // The closing count is held until the next window ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_ff <= rxcks_pkg::RXCKS_BYTE_RST;
    end else if (hf_rise && edge_ff == rxcks_pkg::RXCKS_WIN_LAST) begin
      res_ff <= (tick && cnt_ff != 8'hFF) ? nxt_cnt : cnt_ff;
    end
  end

  assign meas.done = done_ff;
  assign meas.count = res_ff;

endmodule

// file: verilog/rxcks_top.sv
`timescale 1ns/10ps
// How it works
// - Read-only 10-bit current slot count, reset zero.
// - Slot counter spans 0 to 383.
// - Reserved bits read zero, writes ignored.
// - Count prescaled clocks per 32 edges, hold.
// - Flag failure when count exceeds upper bound.
// - Flag failure when count below lower bound.
// - Bound comparisons are unsigned.
// - Prescaler divides by two to divider code.
// - Write one clears fail flag; zero ignored.
// - Interrupt when flag and enable both set.
module rxcks_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_high_freq_clock,
  input wire logic rx_slot_clock,
  input wire logic rx_frame_start,
  output logic rx_interrupt
);

  rxcks_pkg::rxcks_cfg_t cfg_ff; // Programmed bounds and divider.
  rxcks_pkg::rxcks_meas_t meas; // Measurement result from the meter.
  logic [9:0] slot_ff; // Current receive slot count.
  logic fail_ff; // Sticky receive clock failure flag.
  logic ien_ff; // Interrupt enable for the failure flag.
  logic [31:0] rdata_ff; // Registered read data.
  logic err_ff; // Registered error response.
  logic hf_rise; // Synchronised observed clock edge.
  logic slot_rise; // Synchronised slot boundary.
  logic frame_rise; // Synchronised frame start.
  logic fail_evt; // Bound violation at window end.
  logic wr_acc; // Write access phase.
  logic rd_acc; // Read access phase.
  logic clr_fail; // Software clear of the failure flag.

  // Returns true when a byte lies outside the unsigned bounds.
  function automatic logic rxcks_out_of_range(input logic [7:0] v,
                                              input logic [7:0] lo,
                                              input logic [7:0] hi);
    rxcks_out_of_range = (v > hi) || (v < lo);
  endfunction

  // Synchroniser for the observed high-frequency clock.
  rxcks_sync u_hf_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(rx_high_freq_clock),
    .rise(hf_rise)
  );

  // Synchroniser for the slot boundary strobe.
  rxcks_sync u_slot_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(rx_slot_clock),
    .rise(slot_rise)
  );

  // Synchroniser for the frame start strobe.
  rxcks_sync u_frame_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(rx_frame_start),
    .rise(frame_rise)
  );

  // Measurement engine.
  rxcks_meter u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .hf_rise(hf_rise),
    .div(cfg_ff.div),
    .meas(meas)
  );

  // APB decode; access phases complete in one cycle.
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign clr_fail = wr_acc && paddr == rxcks_pkg::RXCKS_OFF_ICLR &&
                    pwdata[rxcks_pkg::RXCKS_FAIL_BIT];
  assign fail_evt = meas.done &&
                    rxcks_out_of_range(meas.count, cfg_ff.lower, cfg_ff.upper);

  // Slot counter restarts on a frame and stops at its top value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_ff <= 10'h000;
    end else if (frame_rise) begin
      slot_ff <= 10'h000;
    end else if (slot_rise && slot_ff != rxcks_pkg::RXCKS_SLOT_MAX) begin
      slot_ff <= slot_ff + 10'h001;
    end
  end

  // Writable clock-check fields; the count field and reserved bits drop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff.upper <= rxcks_pkg::RXCKS_BYTE_RST;
      cfg_ff.lower <= rxcks_pkg::RXCKS_BYTE_RST;
      cfg_ff.div <= rxcks_pkg::RXCKS_DIV_RST;
    end else if (wr_acc && paddr == rxcks_pkg::RXCKS_OFF_CHK) begin
      cfg_ff.upper <= pwdata[rxcks_pkg::RXCKS_MAX_LSB +: 8];
      cfg_ff.lower <= pwdata[rxcks_pkg::RXCKS_MIN_LSB +: 8];
      cfg_ff.div <= pwdata[rxcks_pkg::RXCKS_DIV_LSB +: 4];
    end
  end

  // Interrupt enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_ff <= 1'b0;
    end else if (wr_acc && paddr == rxcks_pkg::RXCKS_OFF_IEN) begin
      ien_ff <= pwdata[rxcks_pkg::RXCKS_FAIL_BIT];
    end
  end

  // Sticky failure flag; a new failure wins over a same-cycle clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_ff <= 1'b0;
    end else if (fail_evt) begin
      fail_ff <= 1'b1;
    end else if (clr_fail) begin
      fail_ff <= 1'b0;
    end
  end

  // Level interrupt from the gated flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_interrupt <= 1'b0;
    end else begin
      rx_interrupt <= fail_ff && ien_ff;
    end
  end

  // Read mux; reserved bits read zero and unmapped addresses error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else if (psel && !penable) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      if (paddr == rxcks_pkg::RXCKS_OFF_SLOT) begin
        rdata_ff <= {22'h000000, slot_ff};
      end else if (paddr == rxcks_pkg::RXCKS_OFF_CHK) begin
        rdata_ff <= {meas.count, cfg_ff.upper, cfg_ff.lower,
                     4'h0, cfg_ff.div};
      end else if (paddr == rxcks_pkg::RXCKS_OFF_STAT) begin
        rdata_ff <= {29'h00000000, fail_ff, 2'h0};
      end else if (paddr == rxcks_pkg::RXCKS_OFF_IEN) begin
        rdata_ff <= {29'h00000000, ien_ff, 2'h0};
      end else if (paddr == rxcks_pkg::RXCKS_OFF_ICLR) begin
        rdata_ff <= 32'h0000_0000; // Clear register reads zero.
      end else begin
        err_ff <= 1'b1; // Unmapped address.
      end
    end
  end

  // Data only shows during a read access phase.
  assign prdata = rd_acc ? rdata_ff : 32'h0000_0000;
  assign pslverr = psel && penable && err_ff;

endmodule

// file: test/rxcks_hf_src.sv
`timescale 1ns/10ps
// Free-running observed audio master clock with a settable half period.
module rxcks_hf_src (
  input wire logic [7:0] half_ns,
  output logic hf_clk
);
  // Starts low so the first rising edge comes one half period in.
  // A longer half period gives a slower clock and so a larger count.
  initial begin
    hf_clk = 1'b0;
    forever #(half_ns) hf_clk = ~hf_clk;
  end
endmodule

// file: test/rxcks_top_monitor.sv
`timescale 1ns/10ps
// Watches the bus answers and the interrupt pin of the block.
module rxcks_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rx_interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read access phase at one address.
  sequence rd_at(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  // Write access phase at one address.
  sequence wr_at(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  slot_noerr_a: assert property (rd_at(8'h84) |-> !pslverr)
    else $error("Slot read flagged an error.");
  slot_range_a: assert property (rd_at(8'h84)
    |-> prdata[9:0] <= 10'h17F)
    else $error("Slot count above its top value.");
  slot_resv_a: assert property (rd_at(8'h84)
    |-> prdata[31:10] == 22'h0)
    else $error("Slot spare bits not zero.");
  chk_resv_a: assert property (rd_at(8'h88) |-> prdata[7:4] == 4'h0)
    else $error("Check spare bits not zero.");
  stat_resv_a: assert property (rd_at(8'h80)
    |-> (prdata & 32'hFFFFFFFB) == 32'h0)
    else $error("Status spare bits not zero.");
  unmapped_err_a: assert property (psel && penable && !(paddr inside
    {8'h80, 8'h84, 8'h88, 8'h90, 8'h94}) |-> pslverr)
    else $error("Unmapped access not refused.");
  ien_off_a: assert property (wr_at(8'h90) ##0 !pwdata[2]
    |-> ##2 !rx_interrupt)
    else $error("Interrupt stayed up after disable.");
  irq_flag_a: assert property (rx_interrupt ##0 rd_at(8'h80)
    |-> prdata[2])
    else $error("Interrupt high without fail flag.");
endmodule
bind rxcks_top rxcks_top_monitor rxcks_top_monitor_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .rx_interrupt);

// file: test/tb_rxcks_top.sv
`timescale 1ns/10ps
// Self-checking bench for the receive clock check and slot block.
module tb_rxcks_top;
  logic pclk = 1'b0; // Only the clock process below writes it later.
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic rx_interrupt, hf, perr;
  logic [7:0] paddr;
  logic [7:0] half = 8'h25;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] strb; // Bit 0 is the slot strobe, bit 1 frame start.
  logic [7:0] offs [4] = '{8'h80, 8'h84, 8'h88, 8'h90};
  // Each entry holds fail expected, upper bound and lower bound.
  logic [16:0] cases [4] = '{17'h0FF00, 17'h17F00, 17'h0FF70, 17'h1FFFF};
  int seed, mismatches, tests_run, cyc, h;
  rxcks_hf_src rxcks_hf_src_inst (.half_ns(half), .hf_clk(hf));
  rxcks_top rxcks_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_high_freq_clock(hf), .rx_slot_clock(strb[0]),
    .rx_frame_start(strb[1]), .rx_interrupt);
  // System clock with a 10 ns period.
  always #5 pclk = ~pclk;
  // Ends a hung run as a failure.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      $display("[ERR] %0t run timed out", $time);
      wrap_up;
    end
  end
  // One bus transfer, held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Exact comparison of a word.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Count comparison allowing two ticks of edge jitter.
  task automatic near(input logic [7:0] g, input int e);
    tests_run++;
    if ($isunknown(g) || g > e + 2 || g + 2 < e) begin
      mismatches++;
      $display("[ERR] %0t count %h want %0d", $time, g, e);
    end
  endtask
  // Expected count over 32 observed periods, saturating at 255.
  function automatic int exp_cnt(input int hh, input int d);
    int c;
    c = (64 * hh / 10) >> d;
    return (c > 255) ? 255 : c;
  endfunction
  // Waits three windows so a whole clean window has closed.
  task automatic wins(input int hh);
    repeat (192 * hh / 10 + 20) @(posedge pclk);
  endtask
  // Pulses the strobes k times, slow enough for the synchroniser.
  task automatic pulse(input logic [1:0] m, input int k);
    repeat (k) begin
      strb <= m;
      repeat (3) @(posedge pclk);
      strb <= 2'b00;
      repeat (3) @(posedge pclk);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence of scenarios.
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, strb} = '0;
    seed = 32'hE1508302;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(q, 32'h0);
    end
    apb(1'b0, 8'h8C, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, 8'h84, 32'hFFFFFFFF);
    apb(1'b0, 8'h84, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 8'h88, 32'hFFFFFFF8);
    apb(1'b0, 8'h88, 32'h0);
    chk(q & 32'h00FFFFFF, 32'h00FFFF08);
    // Every legal divider code, 0 to 8, against a random observed rate.
    for (int d = 0; d <= 8; d++) begin
      h = 30 + ($random(seed) & 31);
      half = h[7:0];
      apb(1'b1, 8'h88, {16'h00FF, 12'h000, d[3:0]});
      wins(h);
      apb(1'b0, 8'h88, 32'h0);
      near(q[31:24], exp_cnt(h, d));
    end
    half = 8'h25;
    h = 37;
    // Start the bound cases from a clean flag.
    apb(1'b1, 8'h94, 32'h4);
    // Bound cases at a count near 236, with the enable off for the first two and on for the last two.
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h90, {29'h0, i[1], 2'h0});
      apb(1'b1, 8'h88, {8'h00, cases[i][15:0], 8'h00});
      wins(h);
      apb(1'b0, 8'h80, 32'h0);
      chk(q, {29'h0, cases[i][16], 2'h0});
      chk({31'h0, rx_interrupt}, {31'h0, cases[i][16] & i[1]});
      apb(1'b1, 8'h88, 32'h00FF0000);
      wins(h);
      apb(1'b1, 8'h94, 32'h0);
      apb(1'b0, 8'h80, 32'h0);
      chk(q, {29'h0, cases[i][16], 2'h0});
      apb(1'b1, 8'h94, 32'h4);
      apb(1'b0, 8'h80, 32'h0);
      chk(q, 32'h0);
    end
    // Slot count, frame restart and saturation.
    h = 5 + ($random(seed) & 15);
    pulse(2'b01, h);
    apb(1'b0, 8'h84, 32'h0);
    chk(q, h);
    pulse(2'b10, 1);
    apb(1'b0, 8'h84, 32'h0);
    chk(q, 32'h0);
    pulse(2'b01, 400);
    apb(1'b0, 8'h84, 32'h0);
    chk(q, 32'h17F);
    // A reset in mid-run brings the saturated slot count back to zero.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h84, 32'h0);
    chk(q, 32'h0);
    wrap_up;
  end
endmodule
